// *** obcd_decoder.sv ***
// option byte storage, programming access and decoded configuration
`timescale 1ns/1ps
`default_nettype none
// How it works
// - option bytes have no cpu address; only programming mode reads or writes them
// - erased cells read back as ff
// - byte0 bit7: halt entry with watchdog active causes reset
// - byte0 bit6: 0 hardware watchdog, 1 software enabled
// - byte0 bits5:4: 11 off, 10 low, 01 medium, 00 high threshold
// - byte0 bits3:2 sector zero size; 4k only on factory flash parts
// - byte0 bit1 read-out protection blocks extraction and flash writes
// - erasing options under read-out protection first erases whole program memory
// - user parts ship with options selecting internal rc oscillator
// - mask parts use hard-wired options, not changeable by programming
// - two option bytes carry every setting
// - byte0 bit0 write protection is permanent once set
// - byte1 bit7 maps port c irqs to vector b when 1
// - byte1 bits5:4 select clock source
// - byte1 bit0 low enables doubler; only with 2-4 mhz, never rc
module obcd_decoder
  import obcd_pkg::*;
#(
  parameter bit MASK_PART = 1'b0,
  parameter bit FACTORY_CODED_PART = 1'b0,
  parameter logic [7:0] MASK_B0 = 8'hff,
  parameter logic [7:0] MASK_B1 = 8'hff
)(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic prog_mode_i,
  input wire logic prog_wr_i,
  input wire logic prog_sel_i,
  input wire logic [7:0] prog_wdata_i,
  input wire logic prog_erase_i,
  output logic [7:0] prog_rdata_o,
  output logic mem_erase_o,
  output logic prog_refused_o,
  output obcd_cfg_t cfg_o,
  output logic cfg_error_o,
  output logic ext_irq_vector_a_o,
  output logic ext_irq_vector_b_o
);
  // ************************************************
  // storage
  // ************************************************
  // nonvolatile cells: shipped or hard-wired image, never cleared by reset
  logic [7:0] nv_q [2] = '{MASK_PART ? MASK_B0 : FACTORY_B0, MASK_PART ? MASK_B1 : FACTORY_B1};
  obcd_erase_t erase_q;
  logic locked;
  logic rd_blocked;

  assign locked = MASK_PART || nv_q[0][B0_WRP];
  assign rd_blocked = nv_q[0][B0_RDP];

  // ************************************************
  // parameter checks
  // ************************************************
  // a hard-wired image is never rewritten, so a reserved clock source, or a 4k sector zero on a part not factory coded, is refused up front
  if (MASK_PART && MASK_B1[B1_OSC_HI:B1_OSC_LO] == OSC_RSVD)
  begin : g_mask_osc_chk
    $error("hard-wired option image selects the reserved clock source");
  end
  if (MASK_PART && !FACTORY_CODED_PART && MASK_B0[B0_SZ0_HI:B0_SZ0_LO] == SZ0_4K)
  begin : g_mask_size_chk
    $error("hard-wired option image selects the largest sector zero size");
  end

  // ************************************************
  // option cells
  // ************************************************
  always_ff @(posedge mclk_i)
  begin
    // retained across reset; no access is taken while reset is held
    if (!rst_i && ce_i && prog_mode_i && !MASK_PART && erase_q == OBCD_OPTE)
    begin
      nv_q[0] <= ERASED_BYTE;
      nv_q[1] <= ERASED_BYTE;
    end
    else if (!rst_i && ce_i && prog_mode_i && prog_wr_i && !locked && !rd_blocked)
    begin
      // whole-byte write, so the tool can arm read-out protection
      nv_q[prog_sel_i] <= prog_wdata_i;
    end
  end

  // ************************************************
  // erase sequencing
  // ************************************************
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      erase_q <= OBCD_IDLE;
    else if (ce_i)
    begin
      case (erase_q)
        OBCD_IDLE:
          if (prog_mode_i && prog_erase_i && !locked)
            erase_q <= rd_blocked ? OBCD_MASS : OBCD_OPTE;
        OBCD_MASS: erase_q <= OBCD_OPTE;
        OBCD_OPTE: erase_q <= OBCD_IDLE;
        default: erase_q <= OBCD_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      mem_erase_o <= 1'b0;
    else if (ce_i)
      mem_erase_o <= (erase_q == OBCD_MASS);
  end

  // ************************************************
  // programming port
  // ************************************************
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      prog_rdata_o <= ERASED_BYTE;
      prog_refused_o <= 1'b0;
    end
    else if (ce_i)
    begin
      // outside programming mode the bytes are invisible
      prog_rdata_o <= prog_mode_i ? nv_q[prog_sel_i] : ERASED_BYTE;
      prog_refused_o <= prog_mode_i && (prog_wr_i || prog_erase_i) && locked;
    end
  end

  // ************************************************
  // decoded configuration, captured under reset
  // ************************************************
  always_ff @(posedge mclk_i)
  begin
    if (ce_i && rst_i)
    begin
      cfg_o.watchdog_halt_reset_opt <= nv_q[0][B0_HALT_RST];
      cfg_o.watchdog_type_opt <= nv_q[0][B0_WDG_TYPE];
      cfg_o.voltage_detect_select <= nv_q[0][B0_VDET_HI:B0_VDET_LO];
      cfg_o.sector_zero_size <= nv_q[0][B0_SZ0_HI:B0_SZ0_LO];
      cfg_o.readout_protect <= nv_q[0][B0_RDP];
      cfg_o.write_protect <= nv_q[0][B0_WRP];
      cfg_o.port_c_irq_mapping <= nv_q[1][B1_PCIRQ];
      cfg_o.osc_source_select <= nv_q[1][B1_OSC_HI:B1_OSC_LO];
      cfg_o.osc_range_select <= nv_q[1][B1_RNG_HI:B1_RNG_LO];
      cfg_o.pll_disable <= nv_q[1][B1_PLL_OFF];
      ext_irq_vector_a_o <= !nv_q[1][B1_PCIRQ];
      ext_irq_vector_b_o <= nv_q[1][B1_PCIRQ];
      // illegal combinations flagged, hardware still follows the bytes
      cfg_error_o <= (nv_q[0][B0_SZ0_HI:B0_SZ0_LO] == SZ0_4K && !FACTORY_CODED_PART)
        || (nv_q[1][B1_OSC_HI:B1_OSC_LO] == OSC_RSVD)
        || (!nv_q[1][B1_PLL_OFF] && (nv_q[1][B1_OSC_HI:B1_OSC_LO] == OSC_RC
          || nv_q[1][B1_RNG_HI:B1_RNG_LO] != RNG_MP));
    end
  end

  // ************************************************
  // checks
  // ************************************************
  cfg_hold_a: assert property (@(posedge mclk_i) !rst_i && !$past(rst_i) |-> $stable(cfg_o))
    else $error("configuration changed outside reset");
  hidden_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $past(ce_i) && !$past(prog_mode_i) |-> prog_rdata_o == ERASED_BYTE)
    else $error("option byte visible outside programming mode");
  mass_first_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && erase_q == OBCD_MASS |=> erase_q == OBCD_OPTE ##0 mem_erase_o)
    else $error("option erase not preceded by memory erase");
  irq_map_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ext_irq_vector_a_o != ext_irq_vector_b_o)
    else $error("port c irqs on both or no vector");
  wp_lock_a: assert property (@(posedge mclk_i) nv_q[0][B0_WRP] |=> nv_q[0][B0_WRP])
    else $error("write protection cleared");
  halt_bit_a: assert property (@(posedge mclk_i) ce_i && rst_i
    |=> cfg_o.watchdog_halt_reset_opt == $past(nv_q[0][B0_HALT_RST]))
    else $error("halt reset option not captured");

  // ************************************************
  // capture, flag, access and erase checks
  // ************************************************
  wdg_type_a: assert property (@(posedge mclk_i) ce_i && rst_i
    |=> cfg_o.watchdog_type_opt == $past(nv_q[0][B0_WDG_TYPE]))
    else $error("watchdog type option not captured");
  vdet_cap_a: assert property (@(posedge mclk_i) ce_i && rst_i
    |=> cfg_o.voltage_detect_select == $past(nv_q[0][B0_VDET_HI:B0_VDET_LO]))
    else $error("voltage detect option not captured");
  sz0_cap_a: assert property (@(posedge mclk_i) ce_i && rst_i
    |=> cfg_o.sector_zero_size == $past(nv_q[0][B0_SZ0_HI:B0_SZ0_LO]))
    else $error("sector zero size not captured");
  sz0_err_a: assert property (@(posedge mclk_i) ce_i && rst_i && !FACTORY_CODED_PART
    && nv_q[0][B0_SZ0_HI:B0_SZ0_LO] == SZ0_4K |=> cfg_error_o)
    else $error("largest sector zero size not flagged");
  rdp_cap_a: assert property (@(posedge mclk_i) ce_i && rst_i
    |=> cfg_o.readout_protect == $past(nv_q[0][B0_RDP]))
    else $error("read-out protection not captured");
  wrp_cap_a: assert property (@(posedge mclk_i) ce_i && rst_i
    |=> cfg_o.write_protect == $past(nv_q[0][B0_WRP]))
    else $error("write protection not captured");
  vec_follow_a: assert property (@(posedge mclk_i) ce_i && rst_i
    |=> ext_irq_vector_b_o == $past(nv_q[1][B1_PCIRQ]))
    else $error("port c irq vector not captured");
  osc_src_a: assert property (@(posedge mclk_i) ce_i && rst_i
    |=> cfg_o.osc_source_select == $past(nv_q[1][B1_OSC_HI:B1_OSC_LO]))
    else $error("clock source option not captured");
  pll_cap_a: assert property (@(posedge mclk_i) ce_i && rst_i
    |=> cfg_o.pll_disable == $past(nv_q[1][B1_PLL_OFF]))
    else $error("doubler option not captured");
  erased_ones_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !MASK_PART && ce_i && prog_mode_i && erase_q == OBCD_OPTE
    |=> nv_q[0] == ERASED_BYTE && nv_q[1] == ERASED_BYTE)
    else $error("erased option bytes not all ones");
  rdp_block_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && prog_mode_i && prog_wr_i && rd_blocked && erase_q == OBCD_IDLE
    |=> nv_q[0] == $past(nv_q[0]) && nv_q[1] == $past(nv_q[1]))
    else $error("write landed under read-out protection");
  lock_refuse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && prog_mode_i && prog_wr_i && locked |=> prog_refused_o)
    else $error("write to locked option bytes not refused");
  lock_erase_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && prog_mode_i && prog_erase_i && locked && erase_q == OBCD_IDLE |=> prog_refused_o && erase_q == OBCD_IDLE)
    else $error("erase of locked option bytes not refused");
  mem_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    mem_erase_o && ce_i |=> !mem_erase_o)
    else $error("memory erase pulse longer than one cycle");
endmodule // obcd_decoder
`default_nettype wire

// *** obcd_pkg.sv ***
// package for the option byte configuration decoder
package obcd_pkg;
  // ************************************************
  // byte 0 field positions
  // ************************************************
  localparam int B0_HALT_RST = 7;
  localparam int B0_WDG_TYPE = 6;
  localparam int B0_VDET_HI = 5;
  localparam int B0_VDET_LO = 4;
  localparam int B0_SZ0_HI = 3;
  localparam int B0_SZ0_LO = 2;
  localparam int B0_RDP = 1;
  localparam int B0_WRP = 0;
  // ************************************************
  // byte 1 field positions
  // ************************************************
  localparam int B1_PCIRQ = 7;
  localparam int B1_OSC_HI = 5;
  localparam int B1_OSC_LO = 4;
  localparam int B1_RNG_HI = 3;
  localparam int B1_RNG_LO = 1;
  localparam int B1_PLL_OFF = 0;
  // ************************************************
  // values
  // ************************************************
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] FACTORY_B0 = 8'hfc;
  localparam logic [7:0] FACTORY_B1 = 8'hef;
  localparam logic [1:0] VDET_OFF = 2'h3;
  localparam logic [1:0] SZ0_4K = 2'h3;
  localparam logic [1:0] OSC_RES = 2'h0;
  localparam logic [1:0] OSC_RSVD = 2'h1;
  localparam logic [1:0] OSC_RC = 2'h2;
  localparam logic [2:0] RNG_MP = 3'h1;

  typedef enum logic [2:0] {
    OBCD_IDLE = 3'b001,
    OBCD_MASS = 3'b010,
    OBCD_OPTE = 3'b100
  } obcd_erase_t;

  typedef struct packed {
    logic watchdog_halt_reset_opt;
    logic watchdog_type_opt;
    logic [1:0] voltage_detect_select;
    logic [1:0] sector_zero_size;
    logic readout_protect;
    logic write_protect;
    logic port_c_irq_mapping;
    logic [1:0] osc_source_select;
    logic [2:0] osc_range_select;
    logic pll_disable;
  } obcd_cfg_t;
endpackage

// *** obcd_tool.sv ***
// programming tool model driving the option byte access port
`timescale 1ns/1ps
`default_nettype none
module obcd_tool (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  input wire logic refused_i,
  input wire logic mem_erase_i,
  output logic wr_o,
  output logic sel_o,
  output logic erase_o,
  output logic [7:0] wdata_o
);
  // ****************
  // tool requests
  // ****************
  initial
  begin
    wr_o = 1'b0;
    sel_o = 1'b0;
    erase_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic rd(input logic s, output logic [7:0] d);
    @(posedge mclk_i);
    sel_o <= s;
    repeat (2) @(posedge mclk_i);
    #1 d = rdata_i;
  endtask
  task automatic wr(input logic s, input logic [7:0] d, output logic r);
    @(posedge mclk_i);
    sel_o <= s;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    // released data line flips so a stale value is never read as valid
    wdata_o <= ~d;
    #1 r = refused_i;
  endtask
  task automatic er(output logic m, output logic r);
    @(posedge mclk_i);
    erase_o <= 1'b1;
    @(posedge mclk_i);
    erase_o <= 1'b0;
    #1 r = refused_i;
    m = 1'b0;
    repeat (3)
    begin
      @(posedge mclk_i);
      #1 m = m | mem_erase_i;
    end
  endtask
endmodule // obcd_tool
`default_nettype wire

// *** option_byte_config_decoder_test.sv ***
// self-checking bench for the option byte configuration decoder
`timescale 1ns/1ps
`default_nettype none
module option_byte_config_decoder_test;
  import obcd_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic mode = 1'b0;
  logic wr, sel, ers, me, rf, cerr, va, vb, m, r;
  logic [7:0] wd, rdat, d;
  obcd_cfg_t cfg;
  int err_count = 0;
  int total_checks = 0;
  always #2 mclk = ~mclk;
  obcd_decoder uut (.mclk_i(mclk), .rst_i(rst), .ce_i(ce), .prog_mode_i(mode), .prog_wr_i(wr),
    .prog_sel_i(sel), .prog_wdata_i(wd), .prog_erase_i(ers), .prog_rdata_o(rdat), .mem_erase_o(me),
    .prog_refused_o(rf), .cfg_o(cfg), .cfg_error_o(cerr), .ext_irq_vector_a_o(va), .ext_irq_vector_b_o(vb));
  obcd_tool tool (.mclk_i(mclk), .rdata_i(rdat), .refused_i(rf), .mem_erase_i(me), .wr_o(wr),
    .sel_o(sel), .erase_o(ers), .wdata_o(wd));
  // ****************
  // helpers and scenarios
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // byte 1 bit 6 is reserved and carries no setting
  function automatic logic [14:0] ex(input logic [7:0] b0, input logic [7:0] b1);
    return {b0, b1[7], b1[5:0]};
  endfunction
  task automatic rst_pulse;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic t_factory;
    chk(cfg, ex(FACTORY_B0, FACTORY_B1));
    chk({va, vb, cerr}, 3'b011);
    chk(rdat, ERASED_BYTE);
  endtask
  task automatic t_program;
    @(posedge mclk);
    mode <= 1'b1;
    tool.rd(1'b0, d);
    chk(d, FACTORY_B0);
    tool.wr(1'b1, 8'h6f, r);
    chk(r, 1'b0);
    tool.wr(1'b0, 8'hf4, r);
    tool.rd(1'b1, d);
    chk(d, 8'h6f);
    // frozen clock enable: a write must not land
    @(posedge mclk);
    ce <= 1'b0;
    tool.wr(1'b0, 8'h00, r);
    @(posedge mclk);
    ce <= 1'b1;
    tool.rd(1'b0, d);
    chk(d, 8'hf4);
    chk(cfg, ex(FACTORY_B0, FACTORY_B1));
    rst_pulse;
    chk(cfg, ex(8'hf4, 8'h6f));
    chk({va, vb, cerr}, 3'b100);
  endtask
  task automatic t_erase;
    tool.wr(1'b0, 8'hf6, r);
    chk(r, 1'b0);
    tool.wr(1'b1, 8'h00, r);
    tool.rd(1'b1, d);
    chk(d, 8'h6f);
    tool.er(m, r);
    chk({m, r}, 2'b10);
    tool.rd(1'b0, d);
    chk(d, ERASED_BYTE);
    tool.rd(1'b1, d);
    chk(d, ERASED_BYTE);
    tool.wr(1'b0, 8'h00, r);
    chk(r, 1'b1);
    tool.er(m, r);
    chk({m, r}, 2'b01);
    rst_pulse;
    chk(cfg, 15'h7fff);
    chk({va, vb, cerr}, 3'b011);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    t_factory;
    t_program;
    t_erase;
    final_report;
  end
  // whole run is under a hundred cycles
  initial
  begin
    #5000;
    err_count++;
    final_report;
  end
endmodule // option_byte_config_decoder_test
`default_nettype wire
